// file: core/ccp_regs_cfg.svh
/*
  Register map, field positions and reset values of the chip clock and
  configuration port register bank.
  Assumes inclusion by bare name from core/.
*/
`ifndef CCP_REGS_CFG_SVH
`define CCP_REGS_CFG_SVH

`define CCP_IDX_CLKCTL      8'h24
`define CCP_IDX_RSVD_A      8'h25
`define CCP_IDX_ADDR_LO     8'h26
`define CCP_IDX_ADDR_HI     8'h27
`define CCP_IDX_RSVD_B_LO   8'h28
`define CCP_IDX_RSVD_B_HI   8'h2a
`define CCP_IDX_TEST4       8'h2b
`define CCP_IDX_TEST5       8'h2c
`define CCP_IDX_TEST1       8'h2d
`define CCP_IDX_TEST2       8'h2e
`define CCP_IDX_TEST3       8'h2f

`define CCP_CLKCTL_RST      8'h04
`define CCP_CLKCTL_WMASK    8'h8e
`define CCP_PLL_OFF_BIT     1
`define CCP_CLK_LSB         2
`define CCP_POL_BIT         7
`define CCP_CLK_STOP        2'h3

`define CCP_ADDR_LO_RST0    8'hf0
`define CCP_ADDR_LO_RST1    8'h70
`define CCP_ADDR_HI_RST     8'h03
`define CCP_TEST_RST        8'h00

`endif

// file: core/ccp_pkg.sv
/*
  Types of the chip clock and configuration port register bank.
  Assumes nothing of its surroundings.
*/
package ccp_pkg;
  typedef logic [7:0]  ccp_byte_t;
  typedef logic [15:0] ccp_addr_t;
endpackage : ccp_pkg

// file: core/ccp_regs.sv
/*
  Chip level clock control and relocatable configuration port registers,
  reached over host index and data ports while configuration mode is on.
  Assumes a synchronous host I/O strobe of one cycle per access.
*/
`timescale 1ns/10ps
`include "ccp_regs_cfg.svh"

module ccp_regs (
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire logic               softReset,
  input  wire logic               strapAlt,
  input  wire logic               configMode,
  input  wire ccp_pkg::ccp_addr_t ioAddr,
  input  wire logic               ioWrite,
  input  wire logic               ioRead,
  input  wire ccp_pkg::ccp_byte_t ioWrData,
  output logic                    ioHit,
  output ccp_pkg::ccp_byte_t      ioRdData,
  output ccp_pkg::ccp_addr_t      cfgPortAddr,
  output logic                    pllEnable,
  output logic                    oscEnable,
  output logic                    baudClockEnable,
  input  wire logic               rtcIrqIn,
  output logic                    rtcInterruptLine
);
  import ccp_pkg::*;

  // ==========================================================
  // Strap capture and port decode
  // ==========================================================
  logic      strapSeen_reg;
  logic      strapVal_reg;
  ccp_byte_t index_reg;
  ccp_byte_t clkCtl_reg;
  ccp_byte_t addrLo_reg;
  ccp_byte_t addrHi_reg;
  ccp_byte_t test4_reg;
  ccp_byte_t test5_reg;
  ccp_byte_t test1_reg;
  ccp_byte_t test2_reg;
  ccp_byte_t test3_reg;
  logic      idxHit;
  logic      dataHit;
  logic      dataWr;
  ccp_byte_t rdMux;

  // The strap is caught on the first edge after reset release.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strapSeen_reg <= 1'b0;
      strapVal_reg  <= 1'b0;
    end else if (!strapSeen_reg) begin
      strapSeen_reg <= 1'b1;
      strapVal_reg  <= strapAlt;
    end
  end

  assign cfgPortAddr = {addrHi_reg, addrLo_reg[7:1], 1'b0};
  assign idxHit  = configMode && (ioAddr == cfgPortAddr);
  assign dataHit = configMode && (ioAddr == {cfgPortAddr[15:1], 1'b1});
  assign dataWr  = dataHit && ioWrite;
  assign ioHit   = (idxHit || dataHit) && (ioWrite || ioRead);

  // ==========================================================
  // Index register
  // ==========================================================
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      index_reg <= 8'h00;
    end else if (softReset) begin
      index_reg <= 8'h00;
    end else if (idxHit && ioWrite) begin
      index_reg <= ioWrData;
    end
  end

  // ==========================================================
  // Clock control register
  // ==========================================================
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clkCtl_reg <= `CCP_CLKCTL_RST;
    end else if (dataWr && index_reg == `CCP_IDX_CLKCTL) begin
      clkCtl_reg <= ioWrData & `CCP_CLKCTL_WMASK;
    end
  end

  assign pllEnable = !clkCtl_reg[`CCP_PLL_OFF_BIT];
  assign oscEnable = clkCtl_reg[`CCP_CLK_LSB +: 2] != `CCP_CLK_STOP;
  assign baudClockEnable = oscEnable;
  assign rtcInterruptLine = rtcIrqIn ^ clkCtl_reg[`CCP_POL_BIT];

  // ==========================================================
  // Configuration port address; soft reset leaves it alone
  // ==========================================================
  logic loLoaded_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addrLo_reg   <= `CCP_ADDR_LO_RST0;
      loLoaded_reg <= 1'b0;
    end else if (!strapSeen_reg) begin
      addrLo_reg <= strapAlt ? `CCP_ADDR_LO_RST1 : `CCP_ADDR_LO_RST0;
    end else if (dataWr && index_reg == `CCP_IDX_ADDR_LO) begin
      addrLo_reg   <= {ioWrData[7:1], 1'b0};
      loLoaded_reg <= 1'b1;
    end else if (dataWr && index_reg == `CCP_IDX_ADDR_HI) begin
      loLoaded_reg <= 1'b0;
    end
  end

  // A write to either address byte moves the port; it takes effect next cycle.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addrHi_reg <= `CCP_ADDR_HI_RST;
    end else if (dataWr && index_reg == `CCP_IDX_ADDR_HI) begin
      addrHi_reg <= ioWrData;
    end
  end

  // ==========================================================
  // Vendor test registers; software is expected to leave them alone
  // ==========================================================
  // Each test register is plain storage with no effect on the clocks.
  // They are kept apart so that a stray write touches exactly one byte.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      test4_reg <= `CCP_TEST_RST;
    end else if (dataWr && index_reg == `CCP_IDX_TEST4) begin
      test4_reg <= ioWrData;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      test5_reg <= `CCP_TEST_RST;
    end else if (dataWr && index_reg == `CCP_IDX_TEST5) begin
      test5_reg <= ioWrData;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      test1_reg <= `CCP_TEST_RST;
    end else if (dataWr && index_reg == `CCP_IDX_TEST1) begin
      test1_reg <= ioWrData;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      test2_reg <= `CCP_TEST_RST;
    end else if (dataWr && index_reg == `CCP_IDX_TEST2) begin
      test2_reg <= ioWrData;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      test3_reg <= `CCP_TEST_RST;
    end else if (dataWr && index_reg == `CCP_IDX_TEST3) begin
      test3_reg <= ioWrData;
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  always_comb begin
    unique case (index_reg)
      `CCP_IDX_CLKCTL:  rdMux = clkCtl_reg;
      `CCP_IDX_ADDR_LO: rdMux = addrLo_reg;
      `CCP_IDX_ADDR_HI: rdMux = addrHi_reg;
      `CCP_IDX_TEST4:   rdMux = test4_reg;
      `CCP_IDX_TEST5:   rdMux = test5_reg;
      `CCP_IDX_TEST1:   rdMux = test1_reg;
      `CCP_IDX_TEST2:   rdMux = test2_reg;
      `CCP_IDX_TEST3:   rdMux = test3_reg;
      default:          rdMux = 8'h00;
    endcase
  end

  // Read data is registered and stands until the next read of the index or data port.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ioRdData <= 8'h00;
    end else if (ioRead && idxHit) begin
      ioRdData <= index_reg;
    end else if (ioRead && dataHit) begin
      ioRdData <= rdMux;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  pll_bit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pllEnable == !clkCtl_reg[1]) else $error("PLL enable disagrees with bit 1.");

  clk_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clkCtl_reg[3:2] == 2'h3) |-> (!oscEnable && !baudClockEnable))
    else $error("Clock code 11 did not stop the clocks.");

  clk_alias_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clkCtl_reg[3:2] == 2'h2) |-> (oscEnable && baudClockEnable))
    else $error("Clock code 10 did not act like 01.");

  irq_pol_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rtcInterruptLine == (clkCtl_reg[7] ? !rtcIrqIn : rtcIrqIn))
    else $error("Interrupt polarity wrong.");

  rsvd_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ioRead && dataHit && (index_reg == 8'h25 || (index_reg >= 8'h28 && index_reg <= 8'h2a)))
    |=> ioRdData == 8'h00) else $error("Reserved location read nonzero.");

  lo_even_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !addrLo_reg[0] && !cfgPortAddr[0]) else $error("Port address bit 0 set.");

  hi_move_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (dataWr && index_reg == 8'h27) |=> cfgPortAddr[15:8] == $past(ioWrData))
    else $error("High byte write did not relocate the port.");

  soft_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (softReset && !dataWr && strapSeen_reg) |=> $stable(cfgPortAddr))
    else $error("Soft reset moved the port.");

  strap_dflt_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !strapSeen_reg |=> cfgPortAddr == ($past(strapAlt) ? 16'h0370 : 16'h03f0))
    else $error("Default port address wrong.");

  mode_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !configMode |-> !ioHit) else $error("Port answered outside configuration mode.");

  // The checks below watch the register updates, the clock enables, the port decode and the read path.
  // Several of them compare against the previous cycle's bus values.
  idx_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (idxHit && ioWrite && !softReset) |=> index_reg == $past(ioWrData))
    else $error("Index write was lost.");

  idx_soft_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    softReset |=> index_reg == 8'h00) else $error("Soft reset left the index.");

  idx_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!(idxHit && ioWrite) && !softReset) |=> $stable(index_reg))
    else $error("Index changed without a write.");

  clk_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clkCtl_reg[3:2] != 2'h3) |-> (oscEnable && baudClockEnable))
    else $error("Clocks stopped for a running code.");

  baud_same_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    baudClockEnable == oscEnable) else $error("Baud clock and oscillator disagree.");

  rsvd_bits_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clkCtl_reg[6:4] == 3'h0) && !clkCtl_reg[0])
    else $error("Reserved clock control bit set.");

  clk_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (dataWr && index_reg == 8'h24) |=> clkCtl_reg == ($past(ioWrData) & 8'h8e))
    else $error("Clock control write wrong.");

  clk_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(dataWr && index_reg == 8'h24) |=> $stable(clkCtl_reg))
    else $error("Clock control changed without a write.");

  rsvd_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (strapSeen_reg && dataWr && (index_reg == 8'h25 ||
      (index_reg >= 8'h28 && index_reg <= 8'h2a)))
    |=> ($stable(clkCtl_reg) && $stable(cfgPortAddr)))
    else $error("Reserved location write took effect.");

  lo_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (dataWr && index_reg == 8'h26) |=> addrLo_reg == {$past(ioWrData[7:1]), 1'b0})
    else $error("Low address byte write wrong.");

  hi_full_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (dataWr && index_reg == 8'h27) |=> addrHi_reg == $past(ioWrData))
    else $error("High address byte write wrong.");

  idx_even_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    idxHit |-> !ioAddr[0]) else $error("Index port hit at an odd address.");

  data_odd_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    dataHit |-> ioAddr[0]) else $error("Data port hit at an even address.");

  addr_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (strapSeen_reg && !(dataWr && (index_reg == 8'h26 || index_reg == 8'h27)))
    |=> $stable(cfgPortAddr)) else $error("Port moved without an address write.");

  test_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (dataWr && index_reg == 8'h2f) |=> test3_reg == $past(ioWrData))
    else $error("Test register write lost.");

  rd_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(ioRead && (idxHit || dataHit)) |=> $stable(ioRdData))
    else $error("Read data changed without a read.");

  rd_data_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ioRead && dataHit) |=> ioRdData == $past(rdMux))
    else $error("Data port read returned the wrong byte.");

  rd_index_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ioRead && idxHit) |=> ioRdData == $past(index_reg))
    else $error("Index port read returned the wrong byte.");

  strobe_hit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ioHit |-> (ioWrite || ioRead)) else $error("Hit without a strobe.");

  mode_decode_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !configMode |-> (!idxHit && !dataHit)) else $error("Decode active outside mode.");

endmodule : ccp_regs

// file: verif/ccp_host_model.sv
/*
  Host side model: drives index and data port cycles on the I/O strobes.
  Assumes the bench calls its tasks after reset and the second edge.
*/
`timescale 1ns/10ps
module ccp_host_model (
  input  wire logic               sys_clk,
  input  wire logic               ioHit,
  input  wire ccp_pkg::ccp_byte_t ioRdData,
  output ccp_pkg::ccp_addr_t      ioAddr,
  output logic                    ioWrite,
  output logic                    ioRead,
  output ccp_pkg::ccp_byte_t      ioWrData
);
  import ccp_pkg::*;
  logic hitSeen;
  initial begin
    ioAddr = 16'hfffe;
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioWrData = 8'h00;
    hitSeen = 1'b0;
  end
  // ==========================================================
  // Port cycles
  // One strobe cycle; the released bus shows inverted values, not the old ones.
  task automatic cycle(input ccp_addr_t a, input logic wr, input ccp_byte_t d);
    @(posedge sys_clk);
    ioAddr <= a;
    ioWrite <= wr;
    ioRead <= !wr;
    ioWrData <= d;
    #1 hitSeen = ioHit;
    @(posedge sys_clk);
    ioWrite <= 1'b0;
    ioRead <= 1'b0;
    ioWrData <= ~d;
    ioAddr <= ~a;
  endtask : cycle
  // Index first, then data port at the next odd address; base is always even.
  task automatic wrReg(input ccp_addr_t b, input ccp_byte_t i, input ccp_byte_t d);
    cycle(b, 1'b1, i);
    cycle(b + 16'h0001, 1'b1, d);
    #1;
  endtask : wrReg
  task automatic rdReg(input ccp_addr_t b, input ccp_byte_t i, output ccp_byte_t d);
    cycle(b, 1'b1, i);
    cycle(b + 16'h0001, 1'b0, 8'h00);
    #1 d = ioRdData;
  endtask : rdReg
endmodule : ccp_host_model

// file: verif/ccp_regs_tb.sv
/*
  Self-checking bench of the clock and configuration port register bank.
  Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/10ps
module ccp_regs_tb;
  import ccp_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, softReset = 1'b0, strapAlt = 1'b0;
  logic configMode = 1'b1, rtcIrqIn = 1'b0, ioWrite, ioRead, ioHit;
  logic pllEnable, oscEnable, baudClockEnable, rtcInterruptLine;
  ccp_addr_t ioAddr, cfgPortAddr;
  ccp_byte_t ioWrData, ioRdData, rd;
  int error_cnt = 0, cmp_count = 0, cycles = 0;
  ccp_regs dut (.sys_clk(sys_clk), .nrst(nrst), .softReset(softReset), .strapAlt(strapAlt),
    .configMode(configMode), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioWrData(ioWrData), .ioHit(ioHit), .ioRdData(ioRdData), .cfgPortAddr(cfgPortAddr),
    .pllEnable(pllEnable), .oscEnable(oscEnable), .baudClockEnable(baudClockEnable),
    .rtcIrqIn(rtcIrqIn), .rtcInterruptLine(rtcInterruptLine));
  ccp_host_model host (.sys_clk(sys_clk), .ioHit(ioHit), .ioRdData(ioRdData),
    .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic do_reset;
    @(posedge sys_clk) nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : do_reset
  // ==========================================================
  // Scenarios
  task automatic test_defaults;
    logic [7:0] idx [6] = '{8'h24, 8'h26, 8'h27, 8'h2b, 8'h2e, 8'h2f};
    logic [7:0] exp [6] = '{8'h04, 8'hf0, 8'h03, 8'h00, 8'h00, 8'h00};
    check(cfgPortAddr, 16'h03f0);
    for (int i = 0; i < 6; i++) begin
      host.rdReg(16'h03f0, idx[i], rd);
      check(rd, exp[i]);
    end
  endtask : test_defaults
  task automatic test_clock;
    ccp_byte_t d;
    for (int i = 0; i < 8; i++) begin
      d = {i[2], 3'h0, i[1:0], i[0], 1'b0};
      @(posedge sys_clk) rtcIrqIn <= i[1];
      host.wrReg(16'h03f0, 8'h24, d);
      host.rdReg(16'h03f0, 8'h24, rd);
      check(rd, d);
      check(pllEnable, !i[0]);
      check(oscEnable, i[1:0] != 2'h3);
      check(baudClockEnable, i[1:0] != 2'h3);
      check(rtcInterruptLine, i[1] ^ i[2]);
    end
  endtask : test_clock
  task automatic test_reserved;
    logic [7:0] idx [5] = '{8'h25, 8'h28, 8'h29, 8'h2a, 8'h30};
    for (int i = 0; i < 5; i++) begin
      host.wrReg(16'h03f0, idx[i], 8'hff);
      host.rdReg(16'h03f0, idx[i], rd);
      check(rd, 8'h00);
    end
  endtask : test_reserved
  task automatic test_reloc;
    host.wrReg(16'h03f0, 8'h26, 8'h35);
    check(cfgPortAddr, 16'h0334);
    host.wrReg(16'h0334, 8'h27, 8'h12);
    check(cfgPortAddr, 16'h1234);
    host.rdReg(16'h1234, 8'h26, rd);
    check(rd, 8'h34);
    host.rdReg(16'h1234, 8'h27, rd);
    check(rd, 8'h12);
    check(host.hitSeen, 1'b1);
    host.cycle(16'h03f0, 1'b1, 8'h24);
    check(host.hitSeen, 1'b0);
    @(posedge sys_clk) configMode <= 1'b0;
    host.cycle(16'h1234, 1'b1, 8'h24);
    check(host.hitSeen, 1'b0);
    @(posedge sys_clk) configMode <= 1'b1;
  endtask : test_reloc
  task automatic test_resets;
    @(posedge sys_clk) softReset <= 1'b1;
    @(posedge sys_clk) softReset <= 1'b0;
    @(posedge sys_clk);
    check(cfgPortAddr, 16'h1234);
    host.cycle(16'h1234, 1'b0, 8'h00);
    #1;
    check(ioRdData, 8'h00);
    strapAlt <= 1'b1;
    do_reset();
    check(cfgPortAddr, 16'h0370);
    host.rdReg(16'h0370, 8'h26, rd);
    check(rd, 8'h70);
  endtask : test_resets
  initial begin
    do_reset();
    test_defaults();
    test_clock();
    test_reserved();
    test_reloc();
    test_resets();
    end_of_test();
  end
endmodule : ccp_regs_tb
